// ==== logic/adc_readout_pkg.sv ====
package adc_readout_pkg;

  // ************************************************************
  // result format
  // ************************************************************
  localparam int unsigned RESULT_BITS = 12;
  localparam int unsigned CNT_W       = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_PS = 10000;
  // conversion duration, fastest grade, in picoseconds
  localparam int unsigned CONVERT_STROBE_TIME_PS  = 1500000;
  localparam int unsigned CONVERT_STROBE_CYCLES   =
    (CONVERT_STROBE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FIFO_DEPTH    = 16;

  typedef enum logic [3:0] {
    ST_ACQUIRE = 4'b0001,
    ST_CONVERT = 4'b0010,
    ST_SLEEP   = 4'b0100,
    ST_READOUT = 4'b1000
  } convert_strobe_state_t;

  typedef struct packed {
    logic [RESULT_BITS-1:0] sample;
  } result_word_t;

endpackage

// ==== logic/sample_fifo.sv ====
`timescale 1ns/1ps
module sample_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                            (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              push  = in_valid_i && !full;
  wire              pop   = out_ready_i && !empty;

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule

// ==== logic/serial_adc_readout.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - rising convert strobe starts a new conversion
// - after conversion, sleep on its own while strobe stays high
// - serial output driven only while strobe is low
// - rising strobe releases serial output to high impedance
// - output changes only on shift clock falling edges and strobe edges, one bit each
// - result shifted most significant bit first
// - twelve result bits, then zeros while strobe stays low
// - falling strobe puts the top result bit out at once
// - low strobe wakes device to track; host waits acquisition interval
module serial_adc_readout #(
  parameter int unsigned CONVERT_STROBE_COUNT = adc_readout_pkg::CONVERT_STROBE_CYCLES
) (
  // clock and reset
  input  wire logic                                    mclk_i,
  input  wire logic                                    sys_rst_i,
  // converter core side
  input  wire logic [adc_readout_pkg::RESULT_BITS-1:0] sample_value_i,
  // pins from host
  input  wire logic                                    convert_strobe_i,
  input  wire logic                                    shift_clk_i,
  // serial result pin
  output logic                                         serial_result_out_o,
  output logic                                         serial_result_oe_o,
  // status
  output logic                                         tracking_o,
  output logic                                         sleeping_o,
  output logic                                         result_ready_o,
  output logic                                         stall_o
);
  import adc_readout_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] strobe_sync;
  logic [1:0] sck_sync;
  logic       strobe_d;
  logic       sck_d;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strobe_sync <= 2'h0;
      sck_sync    <= 2'h0;
      strobe_d    <= 1'b0;
      sck_d       <= 1'b0;
    end else begin
      strobe_sync <= {strobe_sync[0], convert_strobe_i};
      sck_sync    <= {sck_sync[0], shift_clk_i};
      strobe_d    <= strobe_sync[1];
      sck_d       <= sck_sync[1];
    end
  end

  wire strobe_rise = strobe_sync[1] && !strobe_d;
  wire strobe_fall = !strobe_sync[1] && strobe_d;
  wire sck_fall    = !sck_sync[1] && sck_d;

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  localparam int unsigned TW = $clog2(CONVERT_STROBE_COUNT + 1);

  convert_strobe_state_t     state;
  convert_strobe_state_t     next_state;
  logic [TW-1:0]   convert_strobe_timer;
  wire             convert_strobe_done = (convert_strobe_timer == TW'(1));
  wire             fifo_ready;
  wire             fifo_valid;
  result_word_t    fifo_out;
  wire             take_word = strobe_fall && fifo_valid;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_ACQUIRE: begin
        if (strobe_rise) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (convert_strobe_done && fifo_ready) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (strobe_fall) begin
          next_state = ST_READOUT;
        end
      end
      ST_READOUT: begin
        if (strobe_rise) begin
          next_state = ST_CONVERT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_ACQUIRE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      convert_strobe_timer <= '0;
    end else if (strobe_rise) begin
      convert_strobe_timer <= TW'(CONVERT_STROBE_COUNT);
    end else if (convert_strobe_timer > TW'(1)) begin
      convert_strobe_timer <= convert_strobe_timer - TW'(1);
    end
  end

  // ************************************************************
  // result buffer
  // ************************************************************
  wire push_word = (state == ST_CONVERT) && convert_strobe_done;

  sample_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_word),
    .in_ready_o  (fifo_ready),
    .in_data_i   (sample_value_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (take_word),
    .out_data_o  (fifo_out)
  );

  // ************************************************************
  // serial shifter
  // ************************************************************
  logic [RESULT_BITS-1:0] shift_reg;
  logic [CNT_W-1:0]       bit_cnt;
  wire                    bits_left = (bit_cnt != CNT_RESET);
  wire [RESULT_BITS-1:0]  load_word = fifo_valid ? fifo_out.sample
                                                 : '0;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_reg <= '0;
      bit_cnt   <= CNT_RESET;
    end else if (strobe_rise) begin
      bit_cnt   <= CNT_RESET;
    end else if (strobe_fall) begin
      shift_reg <= load_word;
      bit_cnt   <= CNT_W'(RESULT_BITS - 1);
    end else if (sck_fall && !strobe_sync[1]) begin
      shift_reg <= {shift_reg[RESULT_BITS-2:0], 1'b0};
      if (bits_left) begin
        bit_cnt <= bit_cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      serial_result_out_o <= 1'b0;
      serial_result_oe_o  <= 1'b0;
    end else if (strobe_rise) begin
      serial_result_oe_o  <= 1'b0;
      serial_result_out_o <= 1'b0;
    end else if (strobe_fall) begin
      serial_result_oe_o  <= 1'b1;
      serial_result_out_o <= load_word[RESULT_BITS-1];
    end else if (sck_fall && !strobe_sync[1]) begin
      // zeros once all twelve bits have left
      serial_result_out_o <= bits_left ? shift_reg[RESULT_BITS-2]
                                       : 1'b0;
    end
  end

  // ************************************************************
  // status
  // ************************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tracking_o     <= 1'b0;
      sleeping_o     <= 1'b0;
      result_ready_o <= 1'b0;
      stall_o        <= 1'b0;
    end else begin
      tracking_o     <= (next_state == ST_ACQUIRE) ||
                        (next_state == ST_READOUT);
      sleeping_o     <= (next_state == ST_SLEEP);
      result_ready_o <= fifo_valid;
      stall_o        <= !fifo_ready;
    end
  end
endmodule

// ==== sim/readout_monitor.sv ====
`timescale 1ns/1ps
module readout_monitor #(
  parameter int unsigned CONVERT_STROBE_COUNT = 20
) (
  // clock, reset and host pins
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic convert_strobe_i,
  input wire logic shift_clk_i,
  // outputs watched
  input wire logic serial_result_out_o,
  input wire logic serial_result_oe_o,
  input wire logic tracking_o,
  input wire logic sleeping_o,
  input wire logic stall_o
);
  int unsigned hi_cnt;
  logic [4:0]  falls;
  logic [6:0]  sck_h;
  logic [6:0]  str_h;
  logic        sck_fall;
  assign sck_fall = sck_h[0] & ~shift_clk_i;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_cnt <= 0;
      falls  <= 5'h00;
      sck_h  <= 7'h7f;
      str_h  <= 7'h00;
    end else begin
      hi_cnt <= convert_strobe_i ? hi_cnt + 1 : 0;
      falls  <= convert_strobe_i ? 5'h00
                                 : falls + 5'(sck_fall && falls < 5'h1f);
      sck_h  <= {sck_h[5:0], shift_clk_i};
      str_h  <= {str_h[5:0], convert_strobe_i};
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rise;
    $rose(convert_strobe_i) ##1 convert_strobe_i [*4];
  endsequence
  sequence s_drop;
    $fell(convert_strobe_i) ##1 !convert_strobe_i [*4];
  endsequence
  property p_quiet; convert_strobe_i [*6] |-> !serial_result_oe_o; endproperty
  property p_release; s_rise |-> !serial_result_oe_o; endproperty
  property p_enable;
    s_drop |-> serial_result_oe_o && tracking_o && !sleeping_o;
  endproperty
  property p_edge;
    $changed(serial_result_out_o) && serial_result_oe_o |->
      |(sck_h[6:1] & ~sck_h[5:0]) || (str_h != 7'h00 && str_h != 7'h7f);
  endproperty
  property p_stay; sleeping_o && convert_strobe_i |=> sleeping_o; endproperty
  property p_sleep;
    hi_cnt == CONVERT_STROBE_COUNT + 8 |-> sleeping_o || stall_o;
  endproperty
  property p_start;
    hi_cnt > 4 && hi_cnt < CONVERT_STROBE_COUNT |-> !sleeping_o;
  endproperty
  property p_zeros;
    sck_fall && falls > 5'h0a && !convert_strobe_i |->
      ##6 (!serial_result_out_o || !serial_result_oe_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("driven while high");
  a_release: assert property (p_release) else $error("not released");
  a_enable: assert property (p_enable) else $error("not enabled");
  a_edge: assert property (p_edge) else $error("change off edge");
  a_stay: assert property (p_stay) else $error("left sleep");
  a_sleep: assert property (p_sleep) else $error("no sleep");
  a_start: assert property (p_start) else $error("no restart");
  a_zeros: assert property (p_zeros) else $error("no zero fill");
endmodule

bind serial_adc_readout readout_monitor #(
  .CONVERT_STROBE_COUNT (CONVERT_STROBE_COUNT)
) u_mon (
  .mclk_i              (mclk_i),
  .sys_rst_i           (sys_rst_i),
  .convert_strobe_i    (convert_strobe_i),
  .shift_clk_i         (shift_clk_i),
  .serial_result_out_o (serial_result_out_o),
  .serial_result_oe_o  (serial_result_oe_o),
  .tracking_o          (tracking_o),
  .sleeping_o          (sleeping_o),
  .stall_o             (stall_o)
);

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model #(
  parameter int unsigned ACQ = 50
) (
  // clock and result pin
  input  wire logic mclk_i,
  input  wire logic sdo_i,
  input  wire logic oe_i,
  // host pins
  output logic      strobe_o,
  output logic      sck_o
);
  logic last = 1'b0;
  logic pin;
  initial begin
    strobe_o = 1'b0;
    sck_o    = 1'b1;
  end
  // released line shows inverse of last driven bit
  always @(posedge mclk_i) begin
    if (oe_i)
      last <= sdo_i;
  end
  assign pin = oe_i ? sdo_i : ~last;
  task automatic raise(input int hold);
    repeat (ACQ) @(negedge mclk_i);
    strobe_o = 1'b1;
    repeat (hold) @(negedge mclk_i);
  endtask
  task automatic drop();
    strobe_o = 1'b0;
    repeat (6) @(negedge mclk_i);
  endtask
  task automatic shift(input int n, output logic [15:0] w);
    w = {15'h0000, pin};
    for (int i = 1; i < n; i++) begin
      sck_o = 1'b0;
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b1;
      w = {w[14:0], pin};
      repeat (4) @(negedge mclk_i);
    end
  endtask
endmodule

// ==== sim/serial_adc_readout_tb.sv ====
`timescale 1ns/1ps
module serial_adc_readout_tb;
  localparam int unsigned CONVERT_STROBE = 20;
  localparam logic [11:0] EDGE_VALS [3] = '{12'h800, 12'h001, 12'hfff};
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [11:0] sample = 12'h000;
  logic        strobe;
  logic        sck;
  logic        serial_result_out;
  logic        oe;
  logic        trk;
  logic        slp;
  logic        rdy;
  logic        stl;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  serial_adc_readout #(.CONVERT_STROBE_COUNT(CONVERT_STROBE)) dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sample_value_i(sample),
    .convert_strobe_i(strobe), .shift_clk_i(sck),
    .serial_result_out_o(serial_result_out), .serial_result_oe_o(oe),
    .tracking_o(trk), .sleeping_o(slp), .result_ready_o(rdy), .stall_o(stl)
  );
  host_model host (
    .mclk_i(mclk_i), .sdo_i(serial_result_out), .oe_i(oe), .strobe_o(strobe), .sck_o(sck)
  );
  always #5 mclk_i = ~mclk_i;
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic convert(input logic [11:0] v);
    sample = v;
    host.raise(CONVERT_STROBE + 12);
    chk("released", 16'h0, 16'(oe));
    chk("asleep", 16'h1, 16'(slp));
    chk("ready", 16'h1, 16'(rdy));
    chk("stall", 16'h0, 16'(stl));
    host.drop();
    chk("enabled", 16'h1, 16'(oe));
    chk("awake", 16'h1, 16'(trk));
    chk("woken", 16'h0, 16'(slp));
    chk("drained", 16'h0, 16'(rdy));
  endtask
  task automatic read_full();
    logic [15:0] w;
    convert(12'ha5c);
    host.shift(16, w);
    chk("frame16", 16'ha5c0, w);
  endtask
  task automatic read_edges();
    logic [15:0] w;
    foreach (EDGE_VALS[i]) begin
      convert(EDGE_VALS[i]);
      host.shift(12, w);
      chk("frame12", {4'h0, EDGE_VALS[i]}, w);
    end
  endtask
  task automatic read_abort();
    logic [15:0] w;
    convert(12'h3c3);
    host.shift(5, w);
    chk("part5", 16'h0007, w);
    convert(12'h5a5);
    host.shift(12, w);
    chk("restart", 16'h05a5, w);
  endtask
  initial begin
    repeat (5) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    read_full();
    read_edges();
    read_abort();
    wrap_up();
  end
endmodule
